//--- shared/spi_fmt_regs.svh
`ifndef SPI_FMT_REGS_SVH
`define SPI_FMT_REGS_SVH

// rate select codes
`define RATE_BY_TWO 2'h0
`define RATE_BY_EIGHT 2'h1
`define RATE_BY_THIRTY_TWO 2'h2
`define RATE_BY_ONE_TWENTY_EIGHT 2'h3

// bus cycles per half bit time
`define HALF_BY_TWO 7'h01
`define HALF_BY_EIGHT 7'h04
`define HALF_BY_THIRTY_TWO 7'h10
`define HALF_BY_ONE_TWENTY_EIGHT 7'h40

// bits per frame
`define FRAME_BITS 4'h8

`endif

//--- shared/spi_fmt_pkg.sv
package spi_fmt_pkg;

  typedef struct packed {
    logic module_enable_bit;
    logic master_select_bit;
    logic cpol;
    logic cpha;
    logic rate_select_high;
    logic rate_select_low;
  } ctrl_t;

  typedef struct packed {
    logic serial_clock_pin;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_t;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } state_t;

endpackage

//--- hw/spi_fmt.sv
// How it works
// - four clock polarity and phase combinations come from two control bits
// - polarity only sets the idle level of the serial clock
// - phase picks select-fall start or first-clock-edge start
// - slave drives its data output only while select is low
// - phase clear: first edge samples the msb, presented from select fall
// - slave, phase clear: select fall starts frame, msb driven at once
// - buffer cannot enter shift register during a frame; loads after it
// - phase set: data driven from first edge, which starts the frame
// - slave, phase set: first clock edge starts frame, msb driven
// - master: a data write starts a transfer; phase does not change delay
// - master start: phase clear idles half cycle, phase set opens with edge
// - master clock divider free-runs only while enabled and master
// - generated clock edges fall at fixed bus clock points
// - start delay at most one bit time: 2, 8, 32 or 128 cycles
// - master-select set means master, clear means slave on external clock
// - write with empty shift register and no frame running loads it at once, empty flag set
`timescale 1ns/1ps
`default_nettype none
`include "spi_fmt_regs.svh"

module spi_fmt import spi_fmt_pkg::*; #(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire ctrl_t ctrl_i,
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic tx_write_i,
  input wire pins_t pins_i,
  output logic tx_empty_o,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic busy_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic miso_o,
  output logic miso_oe_o
);

  // ****************************************
  // mode decode
  // ****************************************
  logic mst;
  logic slv;
  logic cpol;
  logic cpha;
  logic [1:0] rate;
  logic [6:0] half;

  always_comb begin
    mst = ctrl_i.module_enable_bit & ctrl_i.master_select_bit;
    slv = ctrl_i.module_enable_bit & ~ctrl_i.master_select_bit;
    cpol = ctrl_i.cpol;
    cpha = ctrl_i.cpha;
    rate = {ctrl_i.rate_select_high, ctrl_i.rate_select_low};
    unique case (rate)
      `RATE_BY_TWO: half = `HALF_BY_TWO;
      `RATE_BY_EIGHT: half = `HALF_BY_EIGHT;
      `RATE_BY_THIRTY_TWO: half = `HALF_BY_THIRTY_TWO;
      `RATE_BY_ONE_TWENTY_EIGHT: half = `HALF_BY_ONE_TWENTY_EIGHT;
    endcase
  end

  // ****************************************
  // free-running master divider
  // ****************************************
  logic [6:0] cnt;
  logic ph;
  logic [6:0] next_cnt;
  logic next_ph;
  logic tick;

  // held at zero unless enabled as master, to save power
  always_comb begin
    next_cnt = cnt;
    next_ph = ph;
    tick = 1'b0;
    if (!mst) begin
      next_cnt = '0;
      next_ph = 1'b0;
    end else if (cnt == half - 7'h01) begin
      tick = 1'b1;
      next_cnt = '0;
      next_ph = ~ph;
    end else begin
      next_cnt = cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      ph <= 1'b0;
    end else begin
      cnt <= next_cnt;
      ph <= next_ph;
    end
  end

  // ****************************************
  // frame sequencer and data path
  // ****************************************
  state_t state;
  state_t next_state;
  logic [3:0] nb;
  logic [3:0] next_nb;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] next_sh;
  logic [DATA_W-1:0] rsh;
  logic [DATA_W-1:0] next_rsh;
  logic [DATA_W-1:0] txbuf;
  logic [DATA_W-1:0] next_txbuf;
  logic txfull;
  logic next_txfull;
  logic loaded;
  logic next_loaded;
  logic [DATA_W-1:0] next_rx_data;
  logic next_rx_valid;
  logic next_sclk;
  logic sclk_q;
  logic ss_q;

  logic din;
  logic s_edge;
  logic s_lead;
  logic s_trail;
  logic ss_fall;
  logic start_m;
  logic lead;
  logic trail;
  logic [DATA_W-1:0] sampled;

  // ****************************************
  // pin edges and shift strobes
  // ****************************************
  // slave pins are used unsynchronised; an edge is a pin level that differs from its value one bus cycle before
  always_comb begin
    din = mst ? pins_i.miso : pins_i.mosi;
    s_edge = pins_i.serial_clock_pin != sclk_q;
    s_lead = slv & ~pins_i.ss_n & s_edge & (pins_i.serial_clock_pin != cpol);
    s_trail = slv & ~pins_i.ss_n & s_edge & (pins_i.serial_clock_pin == cpol);
    ss_fall = ss_q & ~pins_i.ss_n;
    // start only on a bit boundary of the free-running clock
    start_m = mst & (state == ST_IDLE) & loaded & tick & ~ph;
    lead = s_lead | (mst & tick & (((state == ST_RUN) & (sclk_o == cpol))
           | (start_m & cpha)));
    trail = s_trail | (mst & tick & (state == ST_RUN) & (sclk_o != cpol));
    sampled = {rsh[DATA_W-2:0], din};
  end

  always_comb begin
    next_state = state;
    next_nb = nb;
    next_sh = sh;
    next_rsh = rsh;
    next_txbuf = txbuf;
    next_txfull = txfull;
    next_loaded = loaded;
    next_rx_data = rx_data_o;
    next_rx_valid = 1'b0;
    next_sclk = sclk_o;
    if (!ctrl_i.module_enable_bit) begin
      next_state = ST_IDLE;
      next_nb = '0;
      next_sclk = cpol;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_sclk = cpol;
          if (start_m) begin
            next_state = ST_RUN;
            next_nb = '0;
            if (cpha) begin
              next_sclk = ~cpol;
            end
          end else if (slv && !cpha && ss_fall) begin
            next_state = ST_RUN;
            next_nb = '0;
          end else if (slv && cpha && s_lead) begin
            next_state = ST_RUN;
            next_nb = '0;
          end
        end
        ST_RUN: begin
          if (slv && pins_i.ss_n) begin
            // select lost mid-frame: drop the byte
            next_state = ST_IDLE;
            next_loaded = 1'b0;
          end else begin
            if (mst && tick) begin
              next_sclk = ~sclk_o;
            end
            if (lead) begin
              if (!cpha) begin
                next_rsh = sampled;
                next_nb = nb + 4'h1;
              end else if (nb != 4'h0) begin
                next_sh = sh << 1;
              end
            end
            if (trail) begin
              if (cpha) begin
                next_rsh = sampled;
                next_nb = nb + 4'h1;
                if (nb == `FRAME_BITS - 4'h1) begin
                  next_state = ST_IDLE;
                  next_loaded = 1'b0;
                  next_rx_data = sampled;
                  next_rx_valid = 1'b1;
                end
              end else if (nb == `FRAME_BITS) begin
                next_state = ST_IDLE;
                next_loaded = 1'b0;
                next_rx_data = rsh;
                next_rx_valid = 1'b1;
              end else begin
                next_sh = sh << 1;
              end
            end
          end
        end
      endcase
    end
    // transmit buffer: shift register is locked while a frame runs
    if (tx_write_i) begin
      if (state == ST_IDLE && next_state == ST_IDLE && !loaded) begin
        next_sh = tx_data_i;
        next_loaded = 1'b1;
      end else begin
        // a write to a full buffer overwrites it
        next_txbuf = tx_data_i;
        next_txfull = 1'b1;
      end
    end else if (state == ST_IDLE && next_state == ST_IDLE && !loaded && txfull) begin
      next_sh = txbuf;
      next_loaded = 1'b1;
      next_txfull = 1'b0;
    end
  end

  // ****************************************
  // registers and pin drivers
  // ****************************************
  // every output is a flip-flop, so the pins lag each decision by one bus cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      nb <= '0;
      sh <= '0;
      rsh <= '0;
      txbuf <= '0;
      txfull <= 1'b0;
      loaded <= 1'b0;
      sclk_q <= 1'b0;
      ss_q <= 1'b1;
      tx_empty_o <= 1'b1;
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      busy_o <= 1'b0;
      sclk_o <= 1'b0;
      sclk_oe_o <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      nb <= next_nb;
      sh <= next_sh;
      rsh <= next_rsh;
      txbuf <= next_txbuf;
      txfull <= next_txfull;
      loaded <= next_loaded;
      sclk_q <= pins_i.serial_clock_pin;
      ss_q <= pins_i.ss_n;
      tx_empty_o <= ~next_txfull;
      rx_data_o <= next_rx_data;
      rx_valid_o <= next_rx_valid;
      busy_o <= next_state == ST_RUN;
      sclk_o <= next_sclk;
      sclk_oe_o <= mst;
      mosi_o <= next_sh[DATA_W-1];
      mosi_oe_o <= mst;
      miso_o <= next_sh[DATA_W-1];
      // the driver opens one cycle after select falls and only while selected
      miso_oe_o <= slv & ~pins_i.ss_n;
    end
  end

endmodule
`default_nettype wire

//--- tb/spi_fmt_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spi_fmt_checker import spi_fmt_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire ctrl_t ctrl_i,
  input wire logic tx_write_i,
  input wire pins_t pins_i,
  input wire logic tx_empty_o,
  input wire logic rx_valid_o,
  input wire logic busy_o,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o
);
  // ****
  // start delay counter
  // ****
  logic m, sl, pend, next_pend;
  logic [7:0] cnt, next_cnt, lim;
  assign m = ctrl_i.module_enable_bit & ctrl_i.master_select_bit;
  assign sl = ctrl_i.module_enable_bit & !ctrl_i.master_select_bit & !pins_i.ss_n;
  assign lim = 8'h02 << {ctrl_i.rate_select_high, ctrl_i.rate_select_low, 1'h0};
  // saturates so a stuck start never wraps back under the limit
  always_comb begin
    next_pend = (pend | tx_write_i) & m & !busy_o;
    next_cnt = next_pend ? cnt + {7'h00, cnt != 8'hff} : 8'h00;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 1'h0;
      cnt <= 8'h00;
    end else begin
      pend <= next_pend;
      cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_miso_select: assert property (miso_oe_o |-> !$past(pins_i.ss_n))
    else $error("miso driven while unselected");
  a_slave_drive: assert property (sl ##1 sl |-> miso_oe_o)
    else $error("selected slave not driving miso");
  a_master_pins: assert property (m |=> sclk_oe_o && mosi_oe_o && !miso_oe_o)
    else $error("master pin enables wrong");
  a_idle_level: assert property (m && !busy_o ##1 m && !busy_o && $stable(ctrl_i)
    |-> sclk_o == ctrl_i.cpol)
    else $error("idle clock level wrong");
  a_start_phase0: assert property (m && !ctrl_i.cpha && $rose(busy_o) |-> sclk_o == ctrl_i.cpol)
    else $error("phase 0 start not idle");
  a_start_phase1: assert property (m && ctrl_i.cpha && $rose(busy_o)
    |-> ##[0:1] sclk_o != ctrl_i.cpol)
    else $error("phase 1 start has no edge");
  a_start_delay: assert property (cnt <= lim + 8'h03)
    else $error("transfer start too late");
  a_frame_end: assert property (m && $fell(busy_o) |-> ##[0:1] rx_valid_o)
    else $error("frame end without receive pulse");
  a_buffer_hold: assert property (m && busy_o && !tx_empty_o |=> !tx_empty_o)
    else $error("buffer loaded during frame");
endmodule
bind spi_fmt spi_fmt_checker i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl_i),
  .tx_write_i(tx_write_i), .pins_i(pins_i), .tx_empty_o(tx_empty_o), .rx_valid_o(rx_valid_o),
  .busy_o(busy_o), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_oe_o(mosi_oe_o),
  .miso_oe_o(miso_oe_o));
`default_nettype wire

//--- tb/spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic sel_i,
  input wire logic [7:0] data_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  // ****
  // far-end slave
  // ****
  logic [7:0] sr;
  logic ob;
  logic last;
  // works on the serial clock itself, so it is ready before the next bus edge
  always @(posedge sel_i or sclk_i) begin
    if (sclk_i === last) begin
      sr = data_i;
    end else begin
      if ((sclk_i != cpol_i) == !cpha_i) rx_o = {rx_o[6:0], mosi_i};
      if (sclk_i != cpol_i && cpha_i) begin
        ob = sr[7];
        sr = sr << 1;
      end
      if (sclk_i == cpol_i && !cpha_i) sr = sr << 1;
    end
    last = sclk_i;
  end
  // unselected: inverse of the last bit, never a held value
  assign miso_o = (cpha_i ? ob : sr[7]) ^ !sel_i;
endmodule
`default_nettype wire

//--- tb/test_spi_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_fmt import spi_fmt_pkg::*;;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0, tx_write_i = 1'h0, sck = 1'h0, mo = 1'h0;
  logic ssn = 1'h1, sel = 1'h0, s_miso;
  logic tx_empty_o, rx_valid_o, busy_o, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic [7:0] tx_data_i = 8'h00, sd = 8'h00, m_rx, rx_data_o;
  ctrl_t ctrl = '0;
  pins_t pins;
  int num_errors = 0, compares = 0, cycles = 0;
  assign pins = {sck, mo, s_miso, ssn};
  spi_fmt i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl), .tx_data_i(tx_data_i),
    .tx_write_i(tx_write_i), .pins_i(pins), .tx_empty_o(tx_empty_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .busy_o(busy_o), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o));
  spi_slave_model i_peer (.sclk_i(sclk_o), .mosi_i(mosi_o), .cpol_i(ctrl.cpol),
    .cpha_i(ctrl.cpha), .sel_i(sel), .data_i(sd), .miso_o(s_miso), .rx_o(m_rx));
  // ****
  // helpers
  // ****
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      final_report;
    end
  end
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] d);
    tx_data_i = d;
    tx_write_i = 1'h1;
    cyc(1);
    tx_write_i = 1'h0;
    cyc(1);
  endtask
  // a missing pulse runs into the cycle ceiling
  task automatic wv;
    do begin
      cyc(1);
    end while (rx_valid_o !== 1'h1);
  endtask
  // changes only with the module disabled
  task automatic setup(input ctrl_t c);
    ctrl.module_enable_bit = 1'h0;
    cyc(1);
    ctrl = c;
    sck = c.cpol;
    cyc(1);
    ctrl.module_enable_bit = 1'h1;
    cyc(2);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_master(input logic [1:0] rt, input logic pol, input logic ph, input logic [7:0] b);
    int n;
    sd = ~b;
    setup('{1'h0, 1'h1, pol, ph, rt[1], rt[0]});
    chk({7'h00, sclk_o}, {7'h00, pol});
    sel = 1'h1;
    wr(b);
    chk({7'h00, tx_empty_o}, 8'h01);
    n = 0;
    while (busy_o !== 1'h1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk({7'h00, n <= (2 << (2 * rt)) + 1}, 8'h01);
    wr({b[3:0], b[7:4]});
    chk({7'h00, tx_empty_o}, 8'h00);
    wv;
    chk(rx_data_o, ~b);
    chk(m_rx, b);
    wv;
    chk(m_rx, {b[3:0], b[7:4]});
    sel = 1'h0;
  endtask
  task automatic sframe(input logic [7:0] e, input logic [7:0] w, input logic l);
    logic [7:0] r;
    ssn = 1'h0;
    cyc(2);
    if (!ctrl.cpha) chk({6'h00, miso_oe_o, miso_o}, {6'h00, 1'h1, e[7]});
    if (w != e) wr(w);
    for (int i = 0; i < 8; i++) begin
      if (ctrl.cpha) sck = ~ctrl.cpol;
      mo = ~e[7 - i];
      cyc(4);
      sck = ctrl.cpha ? ctrl.cpol : ~ctrl.cpol;
      r = {r[6:0], miso_o};
      if (!ctrl.cpha || i < 7) cyc(4);
      if (!ctrl.cpha) sck = ctrl.cpol;
    end
    wv;
    chk(r, e);
    chk(rx_data_o, ~e);
    if (!ctrl.cpha || l) ssn = 1'h1;
    cyc(2);
    chk({7'h00, miso_oe_o}, {7'h00, !ssn});
  endtask
  task automatic t_slave(input logic pol, input logic ph, input logic [7:0] b);
    setup('{1'h0, 1'h0, pol, ph, 1'h0, 1'h0});
    wr(b);
    sframe(b, ~b, 1'h0);
    sframe(~b, ~b, 1'h1);
  endtask
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'h1;
    cyc(2);
    for (int k = 0; k < 16; k++) t_master(k[3:2], k[1], k[0], 8'h96 ^ k[7:0]);
    for (int k = 0; k < 4; k++) t_slave(k[1], k[0], 8'ha5 ^ k[7:0]);
    final_report;
  end
endmodule
`default_nettype wire
